// File: common/swdt_pkg.sv
// Package for the supervisory watchdog: register map, field layout,
// reset values, timing constants and shared types.
// Assumes a 100 MHz core clock and an 8-bit register port.
package swdt_pkg;

    // Register addresses
    localparam logic [7:0] SWDT_CFG_ADDR = 8'h17;
    localparam logic [7:0] SWDT_IRQ_STAT_ADDR = 8'h18;
    localparam logic [7:0] SWDT_IRQ_MASK_ADDR = 8'h19;
    localparam logic [7:0] SWDT_COUNT_ADDR = 8'h1a;

    // Configuration field positions
    localparam int SWDT_RSVD_MSB = 7;
    localparam int SWDT_RSVD_LSB = 6;
    localparam int SWDT_PER_MSB = 5;
    localparam int SWDT_PER_LSB = 4;
    localparam int SWDT_ACT_BIT = 3;
    localparam int SWDT_FEED_BIT = 2;
    localparam int SWDT_EN_BIT = 1;
    localparam int SWDT_GUARD_BIT = 0;

    // Interrupt status and mask bit positions
    localparam int SWDT_IRQ_EXPIRE_BIT = 0;
    localparam int SWDT_IRQ_FEED_BIT = 1;

    // Values after reset
    localparam logic [1:0] SWDT_RSVD_RST = 2'h0;
    localparam logic [1:0] SWDT_PER_RST = 2'h3;
    localparam logic SWDT_ACT_RST = 1'h0;
    localparam logic [1:0] SWDT_IRQ_RST = 2'h0;

    // Timeout intervals in seconds
    localparam logic [7:0] SWDT_T16_S = 8'h10;
    localparam logic [7:0] SWDT_T32_S = 8'h20;
    localparam logic [7:0] SWDT_T64_S = 8'h40;
    localparam logic [7:0] SWDT_T128_S = 8'h80;

    // Timebase
    localparam longint SWDT_CLK_PERIOD_NS = 10;
    localparam longint SWDT_SECOND_NS = 1000000000;
    localparam int unsigned SWDT_SECOND_CYCLES = int'(SWDT_SECOND_NS / SWDT_CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        SWDT_IDLE = 2'b00,
        SWDT_RUN = 2'b01,
        SWDT_HOLD = 2'b10
    } swdt_state_t;

    typedef enum logic {
        SWDT_ACT_POWER_OFF = 1'b0,
        SWDT_ACT_POWER_RESET = 1'b1
    } swdt_action_t;

    typedef struct packed {
        logic valid;
        swdt_action_t action;
    } swdt_seq_req_t;

    // Timeout in seconds for a period code
    function automatic logic [7:0] swdt_period_seconds(input logic [1:0] code);
        unique case (code)
            2'h0: swdt_period_seconds = SWDT_T16_S;
            2'h1: swdt_period_seconds = SWDT_T32_S;
            2'h2: swdt_period_seconds = SWDT_T64_S;
            2'h3: swdt_period_seconds = SWDT_T128_S;
        endcase
    endfunction

endpackage

// File: src/swdt_tick.sv
// One-second timebase for the watchdog: a one-cycle enable pulse.
// Assumes run and restart come from the watchdog core in the same clock.
`timescale 1ns/1ps
`default_nettype none

module swdt_tick import swdt_pkg::*; #(
    parameter int unsigned P_CYCLES = SWDT_SECOND_CYCLES
) (
    input wire logic i_clock, // Core clock
    input wire logic i_rst_n, // Synchronised reset, active low
    input wire logic i_run, // Count while high
    input wire logic i_restart, // Restart the second from zero
    output logic o_tick // One pulse per elapsed second
);
    localparam int W = (P_CYCLES > 1) ? $clog2(P_CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(P_CYCLES - 1);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
        end else if (i_restart || !i_run || cnt_reg == LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end

    // Dropped on restart so a fresh interval gets whole seconds
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= i_run && !i_restart && cnt_reg == LAST;
        end
    end

endmodule

`default_nettype wire

// File: src/swdt_top.sv
// Supervisory watchdog core with its register port and interrupt.
// Assumes synchronous bus strobes and factory straps stable after reset.
//
// Overview of operation
// - The two-bit period field picks a timeout of 16, 32, 64 or 128 seconds.
// - Any change of the period field reloads the running count with the new timeout at once.
// - On expiry the action bit picks power-off when 0 and a power reset cycle when 1.
// - Writing 1 to the feed bit restarts the count from the full timeout; writing 0 leaves it alone.
// - With enable at 1 the timer counts down and expires unless fed; with enable at 0 it stands still.
// - With the guard bit at 0, software may both set and clear the enable bit.
// - With the guard bit at 1, clearing enable is ignored but setting it still starts the timer.
// - The guard bit is read-only and set by factory programming at bit 0 of the configuration.
`timescale 1ns/1ps
`default_nettype none

module swdt_top import swdt_pkg::*; #(
    parameter int unsigned P_SECOND_CYCLES = SWDT_SECOND_CYCLES
) (
    input wire logic i_clock, // 100 MHz core clock
    input wire logic i_nrst, // Asynchronous reset, active low
    input wire logic [7:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic i_otp_guard, // Factory disable guard
    input wire logic i_otp_enable, // Factory run enable at power-on
    output logic [7:0] o_rdata, // Read data, cycle after strobe
    output logic o_irq, // Level interrupt
    output logic o_timer_run_enable, // Current enable bit
    output swdt_seq_req_t o_seq_req // Expiry request to sequencer
);
    logic [1:0] rst_sync_reg;
    logic rst_n;

    logic strap_done_reg;
    logic disable_guard_reg;
    logic timer_run_enable_reg;
    logic [1:0] timeout_period_select_reg;
    swdt_action_t expiry_action_select_reg;
    logic [1:0] rsvd_reg;
    logic [7:0] count_reg;
    swdt_state_t state_reg;
    swdt_state_t state_next;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_stat_next;
    logic [1:0] irq_mask_reg;

    logic cfg_wr;
    logic feed_request;
    logic per_change;
    logic en_next;
    logic en_rise;
    logic reload;
    logic [1:0] reload_per;
    logic tick;
    logic expire;
    logic [7:0] rdata_next;

    // Release of the reset through two flops
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Factory straps are caught in the first cycle after release
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            disable_guard_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            disable_guard_reg <= i_otp_guard;
        end
    end

    // Configuration writes are not served while the straps load
    assign cfg_wr = i_wr && strap_done_reg && i_addr == SWDT_CFG_ADDR;
    assign feed_request = cfg_wr && i_wdata[SWDT_FEED_BIT];
    assign per_change = cfg_wr &&
        i_wdata[SWDT_PER_MSB:SWDT_PER_LSB] != timeout_period_select_reg;

    always_comb begin
        en_next = timer_run_enable_reg;
        if (!strap_done_reg) begin
            en_next = i_otp_enable;
        end else if (cfg_wr) begin
            if (i_wdata[SWDT_EN_BIT]) begin
                en_next = 1'b1;
            end else if (!disable_guard_reg) begin
                en_next = 1'b0;
            end
        end
    end

    assign en_rise = en_next && !timer_run_enable_reg;
    assign reload = en_next && (en_rise || feed_request || per_change);
    assign reload_per = cfg_wr ? i_wdata[SWDT_PER_MSB:SWDT_PER_LSB] : timeout_period_select_reg;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_run_enable_reg <= 1'b0;
        end else begin
            timer_run_enable_reg <= en_next;
        end
    end

    // Reserved bits kept as written; software is expected to write zeros
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            timeout_period_select_reg <= SWDT_PER_RST;
            expiry_action_select_reg <= swdt_action_t'(SWDT_ACT_RST);
            rsvd_reg <= SWDT_RSVD_RST;
        end else if (cfg_wr) begin
            timeout_period_select_reg <= i_wdata[SWDT_PER_MSB:SWDT_PER_LSB];
            expiry_action_select_reg <= swdt_action_t'(i_wdata[SWDT_ACT_BIT]);
            rsvd_reg <= i_wdata[SWDT_RSVD_MSB:SWDT_RSVD_LSB];
        end
    end

    swdt_tick #(
        .P_CYCLES(P_SECOND_CYCLES)
    ) u_tick (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_run(state_reg == SWDT_RUN),
        .i_restart(reload),
        .o_tick(tick)
    );

    assign expire = state_reg == SWDT_RUN && tick && count_reg == 8'h01 && en_next && !reload;

    always_comb begin
        state_next = state_reg;
        if (!en_next) begin
            state_next = SWDT_IDLE;
        end else if (reload) begin
            state_next = SWDT_RUN;
        end else if (expire) begin
            state_next = SWDT_HOLD;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SWDT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 8'h00;
        end else if (reload) begin
            count_reg <= swdt_period_seconds(reload_per);
        end else if (state_reg == SWDT_RUN && tick && count_reg > 8'h01) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    // Sequencer request, one cycle, tagged with the action
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_seq_req <= '0;
        end else begin
            o_seq_req.valid <= expire;
            o_seq_req.action <= expiry_action_select_reg;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_timer_run_enable <= 1'b0;
        end else begin
            o_timer_run_enable <= en_next;
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (i_wr && i_addr == SWDT_IRQ_STAT_ADDR) begin
            irq_stat_next = irq_stat_reg & ~i_wdata[1:0];
        end
        irq_stat_next[SWDT_IRQ_EXPIRE_BIT] = irq_stat_next[SWDT_IRQ_EXPIRE_BIT] | expire;
        irq_stat_next[SWDT_IRQ_FEED_BIT] = irq_stat_next[SWDT_IRQ_FEED_BIT] | (feed_request && en_next);
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= SWDT_IRQ_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= SWDT_IRQ_RST;
        end else if (i_wr && i_addr == SWDT_IRQ_MASK_ADDR) begin
            irq_mask_reg <= i_wdata[1:0];
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // Read mux; feed bit always reads back 0 since it acts only on write
    always_comb begin
        rdata_next = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                SWDT_CFG_ADDR: rdata_next = {rsvd_reg, timeout_period_select_reg,
                    expiry_action_select_reg, 1'b0, timer_run_enable_reg, disable_guard_reg};
                SWDT_IRQ_STAT_ADDR: rdata_next = {6'h00, irq_stat_reg};
                SWDT_IRQ_MASK_ADDR: rdata_next = {6'h00, irq_mask_reg};
                SWDT_COUNT_ADDR: rdata_next = count_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_next;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_n);

    period_range_a: assert property (
        state_reg == SWDT_RUN |-> count_reg != 8'h00 &&
            count_reg <= swdt_period_seconds(timeout_period_select_reg))
        else $error("count outside the programmed timeout");

    period_reload_a: assert property (
        per_change && en_next |=> state_reg == SWDT_RUN &&
            count_reg == swdt_period_seconds(timeout_period_select_reg) && !tick)
        else $error("period change did not reload the count");

    expire_action_a: assert property (
        expire |=> o_seq_req.valid && o_seq_req.action == $past(expiry_action_select_reg))
        else $error("expiry request carries the wrong action");

    feed_restart_a: assert property (
        feed_request && en_next |=> count_reg == swdt_period_seconds($past(reload_per)) &&
            state_reg == SWDT_RUN)
        else $error("feed did not restart the full timeout");

    no_feed_hold_a: assert property (
        cfg_wr && !i_wdata[SWDT_FEED_BIT] && !per_change && timer_run_enable_reg &&
            state_reg == SWDT_RUN && !tick |=> $stable(count_reg))
        else $error("write without feed moved the count");

    disabled_still_a: assert property (
        !timer_run_enable_reg |-> state_reg == SWDT_IDLE && !o_seq_req.valid ##1 !tick)
        else $error("timer active while disabled");

    open_clear_a: assert property (
        cfg_wr && !disable_guard_reg && !i_wdata[SWDT_EN_BIT] |=>
            !timer_run_enable_reg && state_reg == SWDT_IDLE)
        else $error("enable not cleared without guard");

    guard_hold_a: assert property (
        cfg_wr && disable_guard_reg && timer_run_enable_reg |=> timer_run_enable_reg)
        else $error("guarded enable was cleared");

    guard_start_a: assert property (
        cfg_wr && i_wdata[SWDT_EN_BIT] && !timer_run_enable_reg |=>
            timer_run_enable_reg && state_reg == SWDT_RUN)
        else $error("enable write did not start the timer");

    guard_fixed_a: assert property (
        strap_done_reg |=> $stable(disable_guard_reg))
        else $error("guard bit changed after strap load");

    request_pulse_a: assert property (
        o_seq_req.valid |=> !o_seq_req.valid)
        else $error("sequencer request longer than one cycle");

    halt_after_a: assert property (
        expire ##1 (!reload && en_next) |-> (state_reg == SWDT_HOLD && $stable(count_reg)) [*2])
        else $error("counting resumed after expiry");

    // Count bookkeeping between reloads
    count_step_a: assert property (
        state_reg == SWDT_RUN && tick && count_reg > 8'h01 && en_next && !reload |=>
            count_reg == $past(count_reg) - 8'h01)
        else $error("running count did not step down on a tick");

    count_stand_a: assert property (
        !(state_reg == SWDT_RUN && tick) && !reload |=> $stable(count_reg))
        else $error("count moved without a tick or reload");

    hold_count_a: assert property (
        state_reg == SWDT_HOLD |-> count_reg == 8'h01)
        else $error("halted timer left its last second");

    expire_flag_a: assert property (
        expire |=> irq_stat_reg[SWDT_IRQ_EXPIRE_BIT])
        else $error("expiry did not set its status bit");

    feed_flag_a: assert property (
        feed_request && en_next |=> irq_stat_reg[SWDT_IRQ_FEED_BIT])
        else $error("accepted feed did not set its status bit");

    guard_set_a: assert property (
        cfg_wr && disable_guard_reg && i_wdata[SWDT_EN_BIT] |=> timer_run_enable_reg)
        else $error("guarded enable write was not taken");

    guard_read_a: assert property (
        strap_done_reg && i_rd && i_addr == SWDT_CFG_ADDR |=>
            o_rdata[SWDT_GUARD_BIT] == disable_guard_reg)
        else $error("guard bit read back wrong");

    cover_power_off_c: cover property (
        o_seq_req.valid && o_seq_req.action == SWDT_ACT_POWER_OFF);
    cover_power_reset_c: cover property (
        o_seq_req.valid && o_seq_req.action == SWDT_ACT_POWER_RESET);
    cover_feed_run_c: cover property (
        state_reg == SWDT_RUN && tick ##[1:20] feed_request);
    cover_guarded_clear_c: cover property (
        cfg_wr && disable_guard_reg && !i_wdata[SWDT_EN_BIT] && timer_run_enable_reg);
    cover_halt_reload_c: cover property (
        state_reg == SWDT_HOLD && per_change && en_next);

endmodule

`default_nettype wire

// File: verification/test_supervisory_watchdog_timer.sv
// Self-checking testbench for the supervisory watchdog top level.
// Assumes the design is built with a short second (4 cycles) and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module test_supervisory_watchdog_timer import swdt_pkg::*;;
    localparam int P = 4;
    logic i_clock, i_nrst, i_wr, i_rd, i_otp_guard, i_otp_enable;
    logic [7:0] i_addr, i_wdata;
    logic [7:0] o_rdata;
    logic o_irq, o_timer_run_enable;
    swdt_seq_req_t o_seq_req;
    int compares = 0;
    int miscompares = 0;
    int cyc = 0;
    int t0, code;
    logic act;
    // Behavioural model of the configuration, enable and status
    logic [7:0] model_cfg;
    logic model_en, model_guard;
    logic [7:0] model_stat;

    swdt_top #(.P_SECOND_CYCLES(P)) DUT (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_otp_guard(i_otp_guard), .i_otp_enable(i_otp_enable),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_timer_run_enable(o_timer_run_enable),
        .o_seq_req(o_seq_req)
    );

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    always @(posedge i_clock) cyc <= cyc + 1;

    function automatic int tsec(input int c);
        return 16 << c;
    endfunction

    task automatic final_report;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic do_reset(input logic g, input logic e);
        @(posedge i_clock);
        i_nrst <= 1'b0;
        i_otp_guard <= g;
        i_otp_enable <= e;
        repeat (2) @(posedge i_clock);
        i_nrst <= 1'b1;
        // Straps land on the third edge; first request on the fourth
        repeat (4) @(posedge i_clock);
        #1;
        model_guard = g;
        model_en = e;
        model_cfg = {2'b00, 2'b11, 1'b0, 1'b0, e, g};
        model_stat = 8'h00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, exp)
    endtask

    // Config write through the model: clearing enable is refused under the guard
    task automatic wr_cfg(input logic [7:0] d);
        wr(SWDT_CFG_ADDR, {2'b00, d[5:0]});
        #1;
        model_en = d[1] | (model_guard & model_en);
        if (d[2] && model_en) model_stat[1] = 1'b1;
        model_cfg = {2'b00, d[5:3], 1'b0, model_en, model_guard};
        `CHK(o_timer_run_enable, model_en)
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge i_clock);
            #1;
            `CHK(o_seq_req.valid, 1'b0)
        end
    endtask

    task automatic wait_exp(input int start, input int secs, input logic a);
        int n = 0;
        do begin
            @(posedge i_clock);
            #1;
            n++;
        end while (o_seq_req.valid !== 1'b1 && n < secs * P + 40);
        `CHK(o_seq_req.valid, 1'b1)
        `CHK((cyc - start >= secs * P - 2) && (cyc - start <= secs * P + 4), 1'b1)
        `CHK(o_seq_req.action, a)
        model_stat[0] = 1'b1;
        quiet(60);
        chk_rd(SWDT_COUNT_ADDR, 8'h01);
    endtask

    initial begin
        #200000;
        miscompares++;
        final_report();
    end

    initial begin
        i_nrst = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_otp_guard = 1'b0;
        i_otp_enable = 1'b0;
        void'($urandom(32'hde7c));
        do_reset(1'b0, 1'b0);
        chk_rd(SWDT_CFG_ADDR, model_cfg);
        chk_rd(SWDT_IRQ_MASK_ADDR, 8'h00);
        wr(8'h20, 8'hff);
        chk_rd(8'h20, 8'h00);
        `CHK(o_timer_run_enable, 1'b0)
        $display("test reset_values done");

        // Every period code, random action; period changes reload a halted timer
        wr(SWDT_IRQ_MASK_ADDR, 8'h01);
        for (code = 0; code < 4; code++) begin
            act = 1'($urandom);
            wr_cfg({2'b00, code[1:0], act, 3'b010});
            t0 = cyc;
            wait_exp(t0, tsec(code), act);
            chk_rd(SWDT_CFG_ADDR, model_cfg);
        end
        $display("test periods done");

        // Level interrupt: status, mask and write-one-to-clear
        repeat (2) @(posedge i_clock);
        #1;
        `CHK(o_irq, 1'b1)
        chk_rd(SWDT_IRQ_STAT_ADDR, model_stat);
        wr(SWDT_IRQ_MASK_ADDR, 8'h00);
        @(posedge i_clock);
        #1;
        `CHK(o_irq, 1'b0)
        wr(SWDT_IRQ_MASK_ADDR, 8'h01);
        @(posedge i_clock);
        #1;
        `CHK(o_irq, 1'b1)
        wr(SWDT_IRQ_STAT_ADDR, 8'h01);
        model_stat = 8'h00;
        @(posedge i_clock);
        #1;
        `CHK(o_irq, 1'b0)
        $display("test interrupt done");

        // Feed with 1 restarts the full interval, a write with 0 does not
        wr_cfg(8'h0a);
        repeat (20 + $urandom % 30) @(posedge i_clock);
        wr_cfg(8'h0e);
        t0 = cyc;
        repeat (20) @(posedge i_clock);
        wr_cfg(8'h0a);
        wait_exp(t0, 16, 1'b1);
        chk_rd(SWDT_IRQ_STAT_ADDR, model_stat);
        wr(SWDT_IRQ_STAT_ADDR, 8'h03);
        model_stat = 8'h00;
        $display("test feed done");

        // Disable stops the timer; re-enable loads the full interval
        wr_cfg(8'h08);
        wr_cfg(8'h0a);
        repeat (30) @(posedge i_clock);
        wr_cfg(8'h08);
        quiet(200);
        wr_cfg(8'h0a);
        t0 = cyc;
        wait_exp(t0, 16, 1'b1);
        $display("test disable done");

        // Guard strap: enable may be set but not cleared, guard bit read-only
        do_reset(1'b1, 1'b0);
        chk_rd(SWDT_CFG_ADDR, model_cfg);
        wr_cfg(8'h02);
        wr_cfg(8'h10);
        t0 = cyc;
        chk_rd(SWDT_CFG_ADDR, 8'h13);
        wait_exp(t0, 32, 1'b0);
        $display("test guard done");

        // Enable strap starts the timer at power-on with the reset period
        do_reset(1'b0, 1'b1);
        `CHK(o_timer_run_enable, 1'b1)
        chk_rd(SWDT_CFG_ADDR, model_cfg);
        $display("test strap_enable done");
        final_report();
    end
endmodule

`default_nettype wire
